// [pcsd_decoder.sv]
/*
 * Programmable chip select 0 decoder with its register file.
 * Assumes bus address, cycle-type and strobes come from the clk domain;
 * registers are reached over a 32-bit Avalon-MM slave with waitrequest.
 */
// Register access over Avalon-MM was chosen for this implementation.

// Behaviour
// RULE1: Select mode 00 never asserts chip select; this is the reset value.
// RULE2: Mode 01 selects on hit with read strobe; mode 10 with write strobe.
// RULE3: Mode 11 selects on any address hit, ignoring strobes.
// RULE4: Start value is low bound, compared with A[7:0] I/O, A[15:8] memory.
// RULE5: End value is upper bound, compared with A[7:0] I/O, A[15:8] memory.
// RULE6: I/O window spans one to 256 bytes, byte granularity.
// RULE7: Memory window spans 256 bytes to 64 KB, 256-byte granularity.
// RULE8: I/O hit also needs upper match register equal to A[15:8].
// RULE9: Memory hit needs upper match low nibble equal to A[19:16].
// RULE10: Space select bit: clear means I/O decode, set means memory decode.
// RULE11: Trap mode raises NMI on none, read, write or both cycle kinds.
// RULE12: Hit needs start<=field<=end, upper match, and matching cycle space.
// RULE13: Start, end, upper match are 8-bit RW registers reset to zero.
module pcsd_decoder
	import pcsd_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [9:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic [1:0] avs_response,
	input wire logic [19:0] sys_addr,
	input wire logic sys_io_cycle,
	input wire logic sys_mem_cycle,
	input wire logic sys_rd_strobe,
	input wire logic sys_wr_strobe,
	output logic cs0_select,
	output logic cs0_nmi
);

	logic [7:0] mode_q;
	logic [7:0] start_q;
	logic [7:0] end_q;
	logic [7:0] upper_q;
	logic [31:0] rdata_q;
	logic [1:0] resp_q;
	logic ack_q;
	logic cs_q;
	logic nmi_q;

	wire logic [7:0] reg_idx;
	wire logic idx_hi_zero;
	wire logic sel_mode;
	wire logic sel_start;
	wire logic sel_end;
	wire logic sel_upper;
	wire logic mapped;
	wire logic bus_req;
	wire logic wr_lane0;
	wire logic [7:0] wbyte;
	wire logic [7:0] rd_byte;
	wire logic hit;
	wire logic [1:0] sel_field;
	wire logic [1:0] trap_field;
	wire logic space_mem;
	wire logic cs_d;
	wire logic nmi_d;

	// Word address = index, byte address = 4 * index
	assign reg_idx = avs_address[7:0];
	assign idx_hi_zero = (avs_address[9:8] == 2'h0);
	assign sel_mode = idx_hi_zero && (reg_idx == PCSD_IDX_MODE);
	assign sel_start = idx_hi_zero && (reg_idx == PCSD_IDX_START);
	assign sel_end = idx_hi_zero && (reg_idx == PCSD_IDX_END);
	assign sel_upper = idx_hi_zero && (reg_idx == PCSD_IDX_UPPER);
	assign mapped = sel_mode || sel_start || sel_end || sel_upper;

	// One wait cycle per access; the answer lands on the second edge
	assign bus_req = (avs_read || avs_write) && !ack_q;
	assign avs_waitrequest = !ack_q;
	assign avs_readdata = rdata_q;
	assign avs_response = resp_q;

	// Writes commit on the edge that ends the request
	assign wr_lane0 = avs_write && ack_q && avs_byteenable[0];
	assign wbyte = avs_writedata[7:0];

	assign rd_byte = sel_mode ? mode_q
		: sel_start ? start_q
		: sel_end ? end_q
		: sel_upper ? upper_q
		: 8'h00; // RULE13

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			resp_q <= 2'h0;
		end else begin
			ack_q <= bus_req;
			rdata_q <= {24'h00_0000, rd_byte};
			// Unmapped index answers SLVERR but still completes
			resp_q <= mapped ? 2'h0 : 2'h2;
		end
	end

	// Reserved bit D6 is never stored and reads as zero
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mode_q <= PCSD_RST_MODE; // RULE1 RULE10 RULE11
		end else if (wr_lane0 && sel_mode) begin
			mode_q <= wbyte & PCSD_MODE_WMASK;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			start_q <= PCSD_RST_START; // RULE13
			end_q <= PCSD_RST_END; // RULE13
			upper_q <= PCSD_RST_UPPER; // RULE13
		end else begin
			if (wr_lane0 && sel_start) begin
				start_q <= wbyte; // RULE13
			end
			if (wr_lane0 && sel_end) begin
				end_q <= wbyte; // RULE13
			end
			if (wr_lane0 && sel_upper) begin
				upper_q <= wbyte; // RULE13
			end
		end
	end

	assign sel_field = mode_q[PCSD_SEL_LSB +: 2];
	assign trap_field = mode_q[PCSD_TRAP_LSB +: 2];
	assign space_mem = mode_q[PCSD_SPACE_BIT]; // RULE10

	pcsd_window_match u_match (
		.addr(sys_addr),
		.io_cycle(sys_io_cycle),
		.mem_cycle(sys_mem_cycle),
		.space_mem(space_mem),
		.win_start(start_q),
		.win_end(end_q),
		.upper_match(upper_q),
		.hit(hit)
	);

	assign cs_d = (sel_field == PCSD_SEL_RD) ? (hit && sys_rd_strobe) // RULE2
		: (sel_field == PCSD_SEL_WR) ? (hit && sys_wr_strobe) // RULE2
		: (sel_field == PCSD_SEL_ADDR) ? hit // RULE3
		: 1'b0; // RULE1

	// NMI also needs the chip select enabled; trap mode picks the strobe
	assign nmi_d = (sel_field != PCSD_SEL_OFF) && hit &&
		(((trap_field == PCSD_TRAP_RD) && sys_rd_strobe) ||
		((trap_field == PCSD_TRAP_WR) && sys_wr_strobe) ||
		((trap_field == PCSD_TRAP_RW) &&
		(sys_rd_strobe || sys_wr_strobe))); // RULE11

	// Registered outputs: one cycle of latency from bus inputs
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cs_q <= 1'b0;
			nmi_q <= 1'b0;
		end else begin
			cs_q <= cs_d;
			nmi_q <= nmi_d;
		end
	end

	assign cs0_select = cs_q;
	assign cs0_nmi = nmi_q;

	// Outputs are registered, so select checks look one edge later
	a_sel_off_quiet: assert property ( // RULE1
		@(posedge clk) disable iff (!rst_n)
		(sel_field == PCSD_SEL_OFF) |=> !cs0_select)
		else $error("chip select asserted while mode is off");

	a_rd_qualified: assert property ( // RULE2
		@(posedge clk) disable iff (!rst_n)
		(sel_field == PCSD_SEL_RD) ##1 cs0_select
		|-> $past(hit) && $past(sys_rd_strobe))
		else $error("read-qualified select without read hit");

	sequence s_rd_hit;
		hit && sys_rd_strobe;
	endsequence

	a_rd_hit_select: assert property ( // RULE2
		@(posedge clk) disable iff (!rst_n)
		(sel_field == PCSD_SEL_RD) ##0 s_rd_hit |=> cs0_select)
		else $error("read-qualified hit did not select");

	a_wr_qualified: assert property ( // RULE2
		@(posedge clk) disable iff (!rst_n)
		(sel_field == PCSD_SEL_WR) && hit && sys_wr_strobe
		|=> cs0_select)
		else $error("write-qualified hit did not select");

	a_wr_no_strobe: assert property ( // RULE2
		@(posedge clk) disable iff (!rst_n)
		(sel_field == PCSD_SEL_WR) && !sys_wr_strobe |=> !cs0_select)
		else $error("write-qualified select without write strobe");

	a_addr_only: assert property ( // RULE3
		@(posedge clk) disable iff (!rst_n)
		(sel_field == PCSD_SEL_ADDR) |=> (cs0_select == $past(hit)))
		else $error("address-only select does not follow hit");

	a_select_needs_hit: assert property ( // RULE12
		@(posedge clk) disable iff (!rst_n)
		cs0_select |-> $past(hit))
		else $error("chip select without an address hit");

	a_io_range: assert property ( // RULE4 RULE5 RULE6
		@(posedge clk) disable iff (!rst_n)
		!space_mem && hit |-> (sys_addr[7:0] >= start_q) &&
		(sys_addr[7:0] <= end_q))
		else $error("io hit outside window");

	a_mem_range: assert property ( // RULE7
		@(posedge clk) disable iff (!rst_n)
		space_mem && hit |-> (sys_addr[15:8] >= start_q) &&
		(sys_addr[15:8] <= end_q))
		else $error("memory hit outside window");

	// The converse checks: an address inside the window must hit
	a_io_window_hit: assert property ( // RULE6 RULE8 RULE12
		@(posedge clk) disable iff (!rst_n)
		!space_mem && sys_io_cycle && (upper_q == sys_addr[15:8]) &&
		(sys_addr[7:0] >= start_q) && (sys_addr[7:0] <= end_q)
		|-> hit)
		else $error("io address inside window did not hit");

	a_mem_window_hit: assert property ( // RULE7 RULE9 RULE12
		@(posedge clk) disable iff (!rst_n)
		space_mem && sys_mem_cycle && (upper_q[3:0] == sys_addr[19:16]) &&
		(sys_addr[15:8] >= start_q) && (sys_addr[15:8] <= end_q)
		|-> hit)
		else $error("memory address inside window did not hit");

	a_io_upper: assert property ( // RULE8 RULE10
		@(posedge clk) disable iff (!rst_n)
		!space_mem && hit |-> (upper_q == sys_addr[15:8]) &&
		sys_io_cycle)
		else $error("io hit with upper mismatch");

	a_mem_upper: assert property ( // RULE9 RULE10
		@(posedge clk) disable iff (!rst_n)
		space_mem && hit |-> (upper_q[3:0] == sys_addr[19:16]) &&
		sys_mem_cycle)
		else $error("memory hit with upper mismatch");

	a_trap_off: assert property ( // RULE11
		@(posedge clk) disable iff (!rst_n)
		(trap_field == PCSD_TRAP_OFF) |=> !cs0_nmi)
		else $error("nmi raised with trap disabled");

	a_nmi_rd: assert property ( // RULE11
		@(posedge clk) disable iff (!rst_n)
		(trap_field == PCSD_TRAP_RD) && (sel_field != PCSD_SEL_OFF)
		##0 s_rd_hit |=> cs0_nmi)
		else $error("read trap on a read hit did not raise nmi");

	a_nmi_needs_hit: assert property ( // RULE11 RULE12
		@(posedge clk) disable iff (!rst_n)
		cs0_nmi |-> $past(hit))
		else $error("nmi without an address hit");

	sequence s_write_start;
		avs_write && sel_start && avs_byteenable[0] && !avs_waitrequest;
	endsequence

	a_start_store: assert property ( // RULE13
		@(posedge clk) disable iff (!rst_n)
		s_write_start |=> (start_q == $past(avs_writedata[7:0])))
		else $error("start register did not store write");

	sequence s_write_end;
		avs_write && sel_end && avs_byteenable[0] && !avs_waitrequest;
	endsequence

	a_end_store: assert property ( // RULE13
		@(posedge clk) disable iff (!rst_n)
		s_write_end |=> (end_q == $past(avs_writedata[7:0])))
		else $error("end register did not store write");

	sequence s_write_upper;
		avs_write && sel_upper && avs_byteenable[0] && !avs_waitrequest;
	endsequence

	a_upper_store: assert property ( // RULE13
		@(posedge clk) disable iff (!rst_n)
		s_write_upper |=> (upper_q == $past(avs_writedata[7:0])))
		else $error("upper match register did not store write");

	// Reserved D6 is masked off on the way in
	sequence s_write_mode;
		avs_write && sel_mode && avs_byteenable[0] && !avs_waitrequest;
	endsequence

	a_mode_store: assert property ( // RULE10 RULE11
		@(posedge clk) disable iff (!rst_n)
		s_write_mode |=> (mode_q ==
		($past(avs_writedata[7:0]) & PCSD_MODE_WMASK)))
		else $error("mode register did not store write");

	// A register changes only through a completed write to its own index
	a_start_hold: assert property ( // RULE13
		@(posedge clk) disable iff (!rst_n)
		!(avs_write && sel_start && !avs_waitrequest)
		|=> $stable(start_q))
		else $error("start register changed without a write");

	a_upper_hold: assert property ( // RULE13
		@(posedge clk) disable iff (!rst_n)
		!(avs_write && sel_upper && !avs_waitrequest)
		|=> $stable(upper_q))
		else $error("upper match register changed without a write");

	// Reset checks carry no disable, since they watch reset itself
	a_reset_clear: assert property ( // RULE13
		@(posedge clk) !rst_n |=> (start_q == PCSD_RST_START) &&
		(end_q == PCSD_RST_END) && (upper_q == PCSD_RST_UPPER))
		else $error("window registers not cleared by reset");

	a_reset_quiet: assert property ( // RULE1
		@(posedge clk) !rst_n |=> (mode_q == PCSD_RST_MODE) &&
		!cs0_select && !cs0_nmi)
		else $error("reset left the mode or an output active");

	sequence s_req_wait;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence

	// Every access sees exactly one wait cycle
	a_wait_once: assert property ( // RULE13
		@(posedge clk) disable iff (!rst_n)
		s_req_wait |=> !avs_waitrequest)
		else $error("request not answered after one wait cycle");

	a_wait_drop: assert property ( // RULE13
		@(posedge clk) disable iff (!rst_n)
		!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");

	a_read_start: assert property ( // RULE13
		@(posedge clk) disable iff (!rst_n)
		s_req_wait ##0 (avs_read && sel_start)
		|=> (avs_readdata == {24'h00_0000, $past(start_q)}))
		else $error("start register read returned wrong data");

	a_unmapped_err: assert property ( // RULE13
		@(posedge clk) disable iff (!rst_n)
		s_req_wait ##0 !mapped |=> (avs_response == 2'h2))
		else $error("unmapped index did not answer with an error");

endmodule

// [pcsd_decoder_bench.sv]
/*
 * Bench for pcsd_decoder: register access over Avalon-MM, decode checks.
 * Assumes the registered select and the slave's own waitrequest timing.
 */
module pcsd_decoder_bench
	import pcsd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [9:0] a = '0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wd = '0;
	logic [31:0] rdat;
	logic [31:0] q;
	logic wq;
	logic [1:0] rsp;
	logic [1:0] rsp_s;
	logic [19:0] sa = '0;
	logic [3:0] k = '0;
	logic cs;
	logic nmi;
	int unsigned cnt;
	int mismatches = 0;
	int samples_checked = 0;
	int cyc = 0;
	int ncs = 0;
	always #5 clk = ~clk;
	pcsd_decoder dut (.clk(clk), .rst_n(rst_n), .avs_address(a),
		.avs_read(rd), .avs_write(wr), .avs_writedata(wd),
		.avs_byteenable(4'h1), .avs_readdata(rdat),
		.avs_waitrequest(wq), .avs_response(rsp), .sys_addr(sa),
		.sys_io_cycle(k[3]), .sys_mem_cycle(k[2]), .sys_rd_strobe(k[1]),
		.sys_wr_strobe(k[0]), .cs0_select(cs), .cs0_nmi(nmi));
	pcsd_periph peer (.clk(clk), .cs(cs), .sel_count(cnt));
	task automatic wrap_up();
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// A hung handshake would otherwise stall the run forever
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			wrap_up();
		end
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			mismatches++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic acc(input logic w, input logic [7:0] i,
		input logic [7:0] d);
		@(posedge clk);
		a <= {2'b00, i};
		rd <= !w;
		wr <= w;
		wd <= {24'h00_0000, d};
		@(posedge clk iff wq === 1'b0);
		q = rdat;
		rsp_s = rsp;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] i, input logic [7:0] e,
		input logic [1:0] r);
		acc(1'b0, i, 8'h00);
		chk(q, {24'h00_0000, e});
		chk({30'h0000_0000, rsp_s}, {30'h0000_0000, r});
	endtask
	// Cycle kind k is {io, mem, read strobe, write strobe}
	task automatic sy(input logic [19:0] ad, input logic [3:0] kk,
		input logic e, input logic m);
		@(posedge clk);
		sa <= ad;
		k <= kk;
		repeat (2) @(posedge clk);
		#1;
		chk({31'h0000_0000, cs}, {31'h0000_0000, e});
		chk({31'h0000_0000, nmi}, {31'h0000_0000, m});
		if (e) begin
			ncs++;
		end
		@(posedge clk);
		k <= 4'h0;
		@(posedge clk);
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		rdc(PCSD_IDX_MODE, 8'h00, 2'b00);
		for (int i = 1; i < 4; i++) begin
			rdc(8'(PCSD_IDX_MODE + i), 8'h00, 2'b00);
		end
		rdc(8'h30, 8'h00, 2'b10);
		acc(1'b1, PCSD_IDX_END, 8'hA5);
		rdc(PCSD_IDX_END, 8'hA5, 2'b00);
		$display("test registers done");
		acc(1'b1, PCSD_IDX_START, 8'h10);
		acc(1'b1, PCSD_IDX_END, 8'h20);
		acc(1'b1, PCSD_IDX_UPPER, 8'h12);
		for (int m = 0; m < 4; m++) begin
			acc(1'b1, PCSD_IDX_MODE, 8'(m));
			sy(20'h0_1215, 4'hA, m == 1 || m == 3, 1'b0);
			sy(20'h0_1215, 4'h9, m >= 2, 1'b0);
			sy(20'h0_1215, 4'h8, m == 3, 1'b0);
		end
		sy(20'h0_1210, 4'h8, 1'b1, 1'b0);
		sy(20'h0_120F, 4'h8, 1'b0, 1'b0);
		sy(20'h0_1220, 4'h8, 1'b1, 1'b0);
		sy(20'h0_1221, 4'h8, 1'b0, 1'b0);
		sy(20'h0_1310, 4'h8, 1'b0, 1'b0);
		sy(20'h0_1215, 4'h4, 1'b0, 1'b0);
		acc(1'b1, PCSD_IDX_START, 8'h40);
		acc(1'b1, PCSD_IDX_END, 8'h40);
		sy(20'h0_1240, 4'h8, 1'b1, 1'b0);
		sy(20'h0_1241, 4'h8, 1'b0, 1'b0);
		$display("test io window done");
		acc(1'b1, PCSD_IDX_MODE, 8'h83);
		acc(1'b1, PCSD_IDX_UPPER, 8'hF5);
		acc(1'b1, PCSD_IDX_START, 8'h10);
		acc(1'b1, PCSD_IDX_END, 8'h10);
		sy(20'h5_10AB, 4'h4, 1'b1, 1'b0);
		sy(20'h5_11AB, 4'h4, 1'b0, 1'b0);
		sy(20'h6_10AB, 4'h4, 1'b0, 1'b0);
		sy(20'h5_10AB, 4'h8, 1'b0, 1'b0);
		for (int t = 0; t < 4; t++) begin
			acc(1'b1, PCSD_IDX_MODE, 8'(8'h83 | (t << 2)));
			sy(20'h5_10AB, 4'h6, 1'b1, t[0]);
			sy(20'h5_10AB, 4'h5, 1'b1, t[1]);
		end
		$display("test memory window done");
		acc(1'b1, PCSD_IDX_MODE, 8'hFF);
		rdc(PCSD_IDX_MODE, PCSD_MODE_WMASK, 2'h0);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		rdc(PCSD_IDX_MODE, PCSD_RST_MODE, 2'h0);
		rdc(PCSD_IDX_START, PCSD_RST_START, 2'h0);
		rdc(PCSD_IDX_UPPER, PCSD_RST_UPPER, 2'h0);
		// Zeroed window and upper match make address 0 an io hit
		sy(20'h0_0000, 4'hA, 1'b0, 1'b0);
		$display("test reset done");
		chk(cnt, ncs);
		wrap_up();
	end
endmodule

// [pcsd_periph.sv]
/*
 * Peripheral model on chip select 0: counts the accesses it sees.
 * Assumes an active-high select driven in the clk domain.
 */
module pcsd_periph (
	input wire logic clk,
	input wire logic cs,
	output int unsigned sel_count
);
	timeunit 1ns;
	timeprecision 1ps;
	logic cs_q = 1'b0;
	initial sel_count = 0;
	// Counts rising edges, so a select held over several cycles is one access
	always @(posedge clk) begin
		cs_q <= cs;
		if (cs && !cs_q) begin
			sel_count <= sel_count + 1;
		end
	end
endmodule

// [pcsd_pkg.sv]
/*
 * Package for the programmable chip select 0 decoder: register indices,
 * field positions, reset values and mode encodings.
 * Assumes an 8-bit indexed register space behind a 32-bit Avalon-MM slave.
 */
package pcsd_pkg;

	// Indices are word addresses, so byte address = 4 * index
	localparam logic [7:0] PCSD_IDX_MODE = 8'h20;
	localparam logic [7:0] PCSD_IDX_START = 8'h21;
	localparam logic [7:0] PCSD_IDX_END = 8'h22;
	localparam logic [7:0] PCSD_IDX_UPPER = 8'h23;

	localparam logic [7:0] PCSD_RST_MODE = 8'h00;
	localparam logic [7:0] PCSD_RST_START = 8'h00;
	localparam logic [7:0] PCSD_RST_END = 8'h00;
	localparam logic [7:0] PCSD_RST_UPPER = 8'h00;

	// Mode register fields
	localparam int PCSD_SEL_LSB = 0;
	localparam int PCSD_TRAP_LSB = 2;
	localparam int PCSD_MON_BIT = 4;
	localparam int PCSD_DSIZE_BIT = 5;
	localparam int PCSD_SPACE_BIT = 7;
	localparam logic [7:0] PCSD_MODE_WMASK = 8'hBF;

	// Select mode encodings
	localparam logic [1:0] PCSD_SEL_OFF = 2'h0;
	localparam logic [1:0] PCSD_SEL_RD = 2'h1;
	localparam logic [1:0] PCSD_SEL_WR = 2'h2;
	localparam logic [1:0] PCSD_SEL_ADDR = 2'h3;

	// Trap mode encodings
	localparam logic [1:0] PCSD_TRAP_OFF = 2'h0;
	localparam logic [1:0] PCSD_TRAP_RD = 2'h1;
	localparam logic [1:0] PCSD_TRAP_WR = 2'h2;
	localparam logic [1:0] PCSD_TRAP_RW = 2'h3;

endpackage

// [pcsd_window_match.sv]
/*
 * Address window comparator for chip select 0.
 * Assumes the system bus address and cycle type are sampled in clk domain.
 */
module pcsd_window_match
	import pcsd_pkg::*;
(
	input wire logic [19:0] addr,
	input wire logic io_cycle,
	input wire logic mem_cycle,
	input wire logic space_mem,
	input wire logic [7:0] win_start,
	input wire logic [7:0] win_end,
	input wire logic [7:0] upper_match,
	output logic hit
);

	wire logic [7:0] cmp_field;
	wire logic upper_ok;
	wire logic in_range;
	wire logic space_ok;

	// I/O compares A[7:0]; memory compares A[15:8] (256-byte blocks)
	assign cmp_field = space_mem ? addr[15:8] : addr[7:0]; // RULE4 RULE5 RULE6 RULE7
	// Memory ignores the upper nibble of the match register
	assign upper_ok = space_mem ? (upper_match[3:0] == addr[19:16]) // RULE9
		: (upper_match == addr[15:8]); // RULE8
	assign in_range = (cmp_field >= win_start) && (cmp_field <= win_end); // RULE12
	assign space_ok = space_mem ? mem_cycle : io_cycle; // RULE10
	assign hit = in_range && upper_ok && space_ok; // RULE12

endmodule
